// ### tmh_pkg.sv
// Shared constants for the hardware-limit timer mode controller.
// Assumes an 8-bit register port with one-cycle strobes on clk_sys.
package tmh_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // Register indices on the plain register port
  localparam logic [2:0] OFS_COUNT  = 3'h0;
  localparam logic [2:0] OFS_PERIOD = 3'h1;
  localparam logic [2:0] OFS_CTRL   = 3'h2;
  localparam logic [2:0] OFS_MODE   = 3'h3;
  localparam logic [2:0] OFS_STATUS = 3'h4;

  // Control register fields
  localparam int unsigned CTRL_ON_BIT    = 7;
  localparam int unsigned CTRL_CKPS_LSB  = 4;
  localparam int unsigned CTRL_POSTSCALE_SELECT_LSB = 0;

  // Status register fields
  localparam int unsigned STAT_RUN_BIT   = 0;
  localparam int unsigned STAT_WAIT_BIT  = 1;
  localparam int unsigned STAT_ERS_BIT   = 2;
  localparam int unsigned STAT_DEBUG_BIT = 3;

  // Reset values
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [4:0] MODE_RESET   = 5'h00;

  // Mode field: class in [4:3], option in [2:0]
  localparam logic [1:0] CLS_FREE    = 2'h0;
  localparam logic [1:0] CLS_ONESHOT = 2'h1;
  localparam logic [1:0] CLS_MONO    = 2'h2;
  localparam logic [2:0] OPT_SOFT     = 3'h0;
  localparam logic [2:0] OPT_GATE_HI  = 3'h1;
  localparam logic [2:0] OPT_GATE_LO  = 3'h2;
  localparam logic [2:0] OPT_ANY_EDGE = 3'h3;
  localparam logic [2:0] OPT_RISE     = 3'h4;
  localparam logic [2:0] OPT_FALL     = 3'h5;
  localparam logic [2:0] OPT_LVL_LO   = 3'h6;
  localparam logic [2:0] OPT_LVL_HI   = 3'h7;

  // Spacing the trigger source must respect, in timer ticks
  localparam int unsigned ERS_EDGE_GAP_TICKS  = 6;
  localparam int unsigned ERS_LEVEL_MIN_TICKS = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } tmh_state_t;

endpackage

// ### tmh_sync.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ns
module tmh_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

// ### tmh_scaler.sv
// Wrap-around divider counter used for both prescaler and postscaler.
// Assumes limit is stable between clears; hit is combinational.
`timescale 1ns/1ns
module tmh_scaler #(
  parameter int unsigned WIDTH = 7
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             clear,
  input  wire logic             advance,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  hit
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;

  assign hit      = advance && (cnt == limit);
  assign next_cnt = hit ? '0 : cnt + WIDTH'(1);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
    end else if (clear) begin
      cnt <= '0;
    end else if (advance) begin
      cnt <= next_cnt;
    end
  end
endmodule

// ### tmh_mode_ctrl.sv
// Mode controller for an 8-bit period timer with hardware limit operation.
// Assumes a register master on clk_sys and asynchronous trigger and debug pins.
// How it works
// [RULE1] Mode bits [4:3] choose class, bits [2:0] choose start/reset/stop option.
// [RULE2] Trigger source keeps six timer ticks between edges in edge modes.
// [RULE3] Trigger source holds a level three timer ticks in level modes.
// [RULE4] Trigger activity is ignored while debug is active.
// [RULE5] Gate modes count only with enable and the selected trigger level.
// [RULE6] Edge-reset free modes count while enabled; chosen edge clears the count.
// [RULE7] Level-reset free modes hold count cleared during the reset level.
// [RULE8] Software one-shot starts on enable alone, ignoring the trigger.
// [RULE9] Edge-start one-shot needs enable and the chosen trigger edge.
// [RULE10] One-shot options 100-111 use trigger for both start and count reset.
// [RULE11] One-shot match clears enable and parks the count at zero.
// [RULE12] Monostable starts on edge; match parks count, enable stays set. Level monostable (options 110, 111) clears enable at match instead.
// [RULE13] Level monostable runs on one level, resets on the other.
// [RULE14] After enable recycles, a fresh qualifying edge is needed to start.
// [RULE15] Count equal to period clears on next tick and advances postscaler.
// [RULE16] Count write, control write, reset or trigger reset clears both scalers.
// [RULE17] Software-gate free mode counts every tick while enabled, else holds.
// [RULE18] Reserved mode codes are not to be programmed by software.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ns
module tmh_mode_ctrl
  import tmh_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic              extResetSignal,
  input  wire logic              debugActive,
  output logic                   postscaledPulse,
  output logic                   periodMatch,
  output logic                   timerRunning
);

  generate
    if (CNT_W < 2 || CNT_W > DATA_W) begin : g_bad_width
      $error("CNT_W must lie between 2 and the register data width");
    end
  endgenerate

  function automatic logic addrIs(input logic [ADDR_W-1:0] a, input logic [2:0] ofs);
    addrIs = (a == ofs);
  endfunction

  // Register state
  logic [CNT_W-1:0] countValue;
  logic [CNT_W-1:0] periodValue;
  logic             onBit;
  logic [2:0]       ckps;
  logic [3:0]       postscaleSelect;
  logic [4:0]       modeBits;
  tmh_state_t       state;
  tmh_state_t       next_state;
  logic             ersLast;

  // Synchronised pins
  logic [1:0] pinSync;
  logic       ersSync;
  logic       debugSync;

  tmh_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .asyncIn ({debugActive, extResetSignal}),
    .syncOut (pinSync)
  );

  assign ersSync   = pinSync[0];
  assign debugSync = pinSync[1];

  // Register port decode
  logic wrCount;
  logic wrPeriod;
  logic wrCtrl;
  logic wrMode;
  assign wrCount  = regWr && addrIs(regAddr, OFS_COUNT);
  assign wrPeriod = regWr && addrIs(regAddr, OFS_PERIOD);
  assign wrCtrl   = regWr && addrIs(regAddr, OFS_CTRL);
  assign wrMode   = regWr && addrIs(regAddr, OFS_MODE);

  logic [DATA_W-1:0] ctrlView;
  logic [DATA_W-1:0] statusView;
  logic [DATA_W-1:0] readMux;
  assign ctrlView = {onBit, ckps, postscaleSelect};

  always_comb begin
    statusView                 = '0;
    statusView[STAT_RUN_BIT]   = (state == ST_RUN) || timerRunning;
    statusView[STAT_WAIT_BIT]  = (state == ST_WAIT);
    statusView[STAT_ERS_BIT]   = ersSync;
    statusView[STAT_DEBUG_BIT] = debugSync;
  end

  always_comb begin
    if (addrIs(regAddr, OFS_COUNT)) begin
      readMux = DATA_W'(countValue);
    end else if (addrIs(regAddr, OFS_PERIOD)) begin
      readMux = DATA_W'(periodValue);
    end else if (addrIs(regAddr, OFS_CTRL)) begin
      readMux = ctrlView;
    end else if (addrIs(regAddr, OFS_MODE)) begin
      readMux = {3'h0, modeBits};
    end else if (addrIs(regAddr, OFS_STATUS)) begin
      readMux = statusView;
    end else begin
      readMux = '0;
    end
  end

  // [RULE1] Mode class and option split
  logic [1:0] modeClass;
  logic [2:0] modeOpt;
  assign modeClass = modeBits[4:3];
  assign modeOpt   = modeBits[2:0];

  // Prescaler: divides clk_sys by 2**ckps to make the counting tick
  logic       tick;
  logic       scalerClr;
  logic       extEvt;
  logic [6:0] preLimit;
  assign preLimit = 7'((8'h01 << ckps) - 8'h01);

  tmh_scaler #(
    .WIDTH (7)
  ) u_prescale (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clear   (scalerClr),
    .advance (1'b1),
    .limit   (preLimit),
    .hit     (tick)
  );

  // [RULE4] Debug freezes the trigger at its last sampled level
  logic ersEff;
  logic ersRise;
  logic ersFall;
  logic ersAny;
  assign ersEff  = debugSync ? ersLast : ersSync;
  assign ersRise = ersEff && !ersLast;
  assign ersFall = !ersEff && ersLast;
  assign ersAny  = ersRise || ersFall;

  logic matchNow;
  assign matchNow = (countValue == periodValue);

  // Start edge: options 001 rise, 000 and 010 fall, 011 any, 1x0 rise, 1x1 fall
  logic startEdge;
  logic levelMode;
  logic startLevel;
  assign startEdge = modeOpt[2] ? (modeOpt[0] ? ersFall : ersRise) :
                     (modeOpt == OPT_ANY_EDGE) ? ersAny :
                     (modeOpt == OPT_GATE_HI) ? ersRise : ersFall;
  assign levelMode  = (modeClass == CLS_MONO) && modeOpt[2] && modeOpt[1];
  assign startLevel = modeOpt[0] ? !ersEff : ersEff;

  // [RULE10] Trigger reset inside a running one-shot
  logic oneShotHwReset;
  assign oneShotHwReset = !modeOpt[2] ? 1'b0 :
                          !modeOpt[1] ? (modeOpt[0] ? ersFall : ersRise) :
                          (modeOpt[0] ? ersEff : !ersEff);

  // Free-running gate and reset terms
  logic freeGate;
  logic freeReset;
  always_comb begin
    freeGate  = 1'b1;
    freeReset = 1'b0;
    case (modeOpt)
      // [RULE5] Level gates
      OPT_GATE_HI:  freeGate = ersEff;
      OPT_GATE_LO:  freeGate = !ersEff;
      // [RULE6] Edge resets
      OPT_ANY_EDGE: freeReset = ersAny;
      OPT_RISE:     freeReset = ersRise;
      OPT_FALL:     freeReset = ersFall;
      // [RULE7] Level resets
      OPT_LVL_LO:   freeReset = !ersEff;
      OPT_LVL_HI:   freeReset = ersEff;
      default:      freeGate = 1'b1;
    endcase
  end

  // Per-tick control decisions
  logic step;
  logic cntClr;
  logic hwOffClr;
  always_comb begin
    next_state = state;
    step       = 1'b0;
    cntClr     = 1'b0;
    hwOffClr   = 1'b0;
    extEvt     = 1'b0;
    // [RULE14] Dropping enable forgets any armed start
    if (!onBit) begin
      next_state = ST_IDLE;
    end else if (tick) begin
      case (modeClass)
        CLS_FREE: begin
          // [RULE17] Plain software gate when no trigger term applies
          extEvt = freeReset;
          cntClr = freeReset;
          step   = freeGate && !freeReset;
        end
        CLS_ONESHOT, CLS_MONO: begin
          case (state)
            ST_IDLE: begin
              // [RULE8] Software start needs no trigger
              if (modeClass == CLS_ONESHOT && modeOpt == OPT_SOFT) begin
                next_state = ST_RUN;
              end else begin
                next_state = ST_WAIT;
              end
            end
            ST_WAIT: begin
              if (modeClass == CLS_MONO && (modeOpt == OPT_SOFT || modeOpt == OPT_RISE ||
                  modeOpt == OPT_FALL)) begin
                next_state = ST_WAIT;
              // [RULE13] Level start
              end else if (levelMode) begin
                if (startLevel) begin
                  next_state = ST_RUN;
                end
              // [RULE9] Edge start, fresh edge only
              end else if (startEdge) begin
                next_state = ST_RUN;
              end
            end
            ST_RUN: begin
              if (levelMode && !startLevel) begin
                // [RULE13] Opposite level resets and re-arms
                cntClr     = 1'b1;
                extEvt     = 1'b1;
                next_state = ST_WAIT;
              end else if (modeClass == CLS_ONESHOT && oneShotHwReset) begin
                // [RULE10] Trigger reset of the count
                cntClr = 1'b1;
                extEvt = 1'b1;
              end else begin
                step = 1'b1;
                if (matchNow) begin
                  if (modeClass == CLS_ONESHOT || levelMode) begin
                    // [RULE11] Enable dropped at end of shot
                    hwOffClr   = 1'b1;
                    next_state = ST_IDLE;
                  end else begin
                    // [RULE12] Park and wait, enable kept
                    next_state = ST_WAIT;
                  end
                end
              end
            end
            default: next_state = ST_IDLE;
          endcase
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // [RULE15] Match clears the count on the counting tick after it is seen
  logic             postHit;
  logic             matchStep;
  logic [CNT_W-1:0] next_count;
  assign matchStep  = step && matchNow;
  assign next_count = matchNow ? '0 : countValue + CNT_W'(1);

  // [RULE16] Scaler clear sources
  assign scalerClr = wrCount || wrCtrl || extEvt;

  tmh_scaler #(
    .WIDTH (4)
  ) u_postscale (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clear   (scalerClr),
    .advance (matchStep),
    .limit   (postscaleSelect),
    .hit     (postHit)
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      countValue <= CNT_W'(COUNT_RESET);
    end else if (wrCount) begin
      countValue <= regWdata[CNT_W-1:0];
    end else if (cntClr) begin
      countValue <= '0;
    end else if (step) begin
      countValue <= next_count;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      periodValue <= CNT_W'(PERIOD_RESET);
      modeBits    <= MODE_RESET;
    end else begin
      if (wrPeriod) begin
        periodValue <= regWdata[CNT_W-1:0];
      end
      if (wrMode) begin
        modeBits <= regWdata[4:0];
      end
    end
  end

  // A software write beats a same-cycle end-of-shot clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      onBit           <= CTRL_RESET[CTRL_ON_BIT];
      ckps            <= CTRL_RESET[CTRL_CKPS_LSB +: 3];
      postscaleSelect <= CTRL_RESET[CTRL_POSTSCALE_SELECT_LSB +: 4];
    end else if (wrCtrl) begin
      onBit           <= regWdata[CTRL_ON_BIT];
      ckps            <= regWdata[CTRL_CKPS_LSB +: 3];
      postscaleSelect <= regWdata[CTRL_POSTSCALE_SELECT_LSB +: 4];
    end else if (hwOffClr) begin
      onBit <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state   <= ST_IDLE;
      ersLast <= 1'b0;
    end else begin
      state <= next_state;
      if (tick) begin
        ersLast <= ersEff;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      regRdata        <= '0;
      postscaledPulse <= 1'b0;
      periodMatch     <= 1'b0;
      timerRunning    <= 1'b0;
    end else begin
      regRdata        <= regRd ? readMux : '0;
      postscaledPulse <= postHit;
      periodMatch     <= matchStep;
      timerRunning    <= onBit && (modeClass == CLS_FREE || next_state == ST_RUN);
    end
  end

endmodule

// ### tmh_mode_checker.sv
// Port checker for the timer mode controller, bound onto it.
// Mirrors written registers; timing checks assume prescale 1:1.
`timescale 1ns/1ns
module tmh_mode_checker
  import tmh_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       extResetSignal,
  input wire logic       debugActive,
  input wire logic       postscaledPulse,
  input wire logic       periodMatch,
  input wire logic       timerRunning
);
  logic [7:0] ctrl;
  logic [7:0] period;
  logic [4:0] mode;
  logic [8:0] gap;
  logic       armed;
  wire        onBit = ctrl[CTRL_ON_BIT];
  // Debug freezes the trigger, so level checks stand down then
  wire        calm = ctrl[6:4] == 3'h0 && !debugActive;
  wire        gateShut = calm && (mode == 5'h01 && !extResetSignal || mode == 5'h02 && extResetSignal);
  wire        lvlHold = calm && period != 8'h00 && !mode[3] && mode[2:1] == 2'h3
                        && mode[0] == extResetSignal;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl   <= CTRL_RESET;
      period <= PERIOD_RESET;
      mode   <= MODE_RESET;
      gap    <= 9'h000;
      armed  <= 1'b0;
    end else begin
      if (regWr && regAddr == OFS_CTRL) ctrl <= regWdata;
      if (regWr && regAddr == OFS_PERIOD) period <= regWdata;
      if (regWr && regAddr == OFS_MODE) mode <= regWdata[4:0];
      gap   <= periodMatch ? 9'h001 : gap + {8'h00, gap != 9'h1FF};
      // Any write may move the count, so spacing is only trusted between quiet matches
      armed <= !regWr && (periodMatch || armed);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its slot");
  a_free_period: assert property (
    periodMatch && armed && mode == 5'h00 && calm |-> gap == {1'b0, period} + 9'h001)
    else $error("period match spacing wrong");
  a_free_on: assert property (
    $rose(onBit) && mode == 5'h00 |-> ##[0:3] timerRunning)
    else $error("free timer did not start");
  a_free_off: assert property (
    $fell(onBit) && mode == 5'h00 |-> ##[0:3] !timerRunning)
    else $error("free timer did not stop");
  a_gate_stop: assert property (gateShut [*8] |-> !periodMatch)
    else $error("match while gate shut");
  a_level_hold: assert property (lvlHold [*8] |-> !periodMatch)
    else $error("match while held in reset");
  a_shot_stop: assert property (
    periodMatch && mode[4:3] == CLS_ONESHOT |-> ##[0:3] !timerRunning)
    else $error("one-shot kept running");
  a_soft_start: assert property (
    $rose(onBit) && mode == 5'h08 && calm |-> ##[0:4] timerRunning)
    else $error("software one-shot did not start");
  a_post_match: assert property (postscaledPulse |-> periodMatch)
    else $error("postscaler pulse without a period match");

  c_free_match: cover property (periodMatch && armed);
  c_post_pulse: cover property (postscaledPulse);
  c_shot_end: cover property (periodMatch && mode[4:3] == CLS_ONESHOT);
endmodule

bind tmh_mode_ctrl tmh_mode_checker u_tmh_mode_checker (
  .clk_sys         (clk_sys),
  .resetn          (resetn),
  .regAddr         (regAddr),
  .regWdata        (regWdata),
  .regWr           (regWr),
  .regRd           (regRd),
  .regRdata        (regRdata),
  .extResetSignal  (extResetSignal),
  .debugActive     (debugActive),
  .postscaledPulse (postscaledPulse),
  .periodMatch     (periodMatch),
  .timerRunning    (timerRunning)
);

// ### tmh_ers_src.sv
// Stand-in for the on-chip source of the external reset signal.
// Assumes one timer tick per clk_sys cycle.
`timescale 1ns/1ns
module tmh_ers_src
  import tmh_pkg::*;
#(
  parameter int unsigned MIN_HOLD = ERS_EDGE_GAP_TICKS
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic levelReq,
  output logic      extResetSignal
);
  logic [3:0] held;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      extResetSignal <= 1'b0;
      held           <= 4'h0;
    end else if (levelReq != extResetSignal && held >= MIN_HOLD) begin
      extResetSignal <= levelReq;
      held           <= 4'h0;
    end else if (held != 4'hF) begin
      held <= held + 4'h1;
    end
  end
endmodule

// ### tb.sv
// Self-checking bench for the timer mode controller.
// Assumes prescale 1:1, so one timer tick is one clk_sys cycle.
`timescale 1ns/1ns
module tb
  import tmh_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic       levelReq = 1'b0;
  logic       debugActive = 1'b0;
  logic [7:0] regRdata;
  logic       extResetSignal;
  logic       postscaledPulse;
  logic       periodMatch;
  logic       timerRunning;
  logic [7:0] per;
  logic [7:0] rd;
  logic [4:0] md;
  logic [4:0] lvlModes [4] = '{5'h06, 5'h07, 5'h16, 5'h17};
  logic [4:0] edgeModes [10] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h11,
                                 5'h12, 5'h13};
  int         n_fail = 0;
  int         n_checks = 0;
  int         seed = 87;
  int         matchTotal = 0;
  int         m0;
  int         p0;
  int         pulseTotal = 0;

  always #10 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    if (periodMatch === 1'b1) matchTotal++;
    if (postscaledPulse === 1'b1) pulseTotal++;
  end

  tmh_mode_ctrl u_tmh_mode_ctrl (
    .clk_sys         (clk_sys),
    .resetn          (resetn),
    .regAddr         (regAddr),
    .regWdata        (regWdata),
    .regWr           (regWr),
    .regRd           (regRd),
    .regRdata        (regRdata),
    .extResetSignal  (extResetSignal),
    .debugActive     (debugActive),
    .postscaledPulse (postscaledPulse),
    .periodMatch     (periodMatch),
    .timerRunning    (timerRunning)
  );
  tmh_ers_src u_tmh_ers_src (
    .clk_sys        (clk_sys),
    .resetn         (resetn),
    .levelReq       (levelReq),
    .extResetSignal (extResetSignal)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    d = regRdata;
  endtask

  // The source may lag a request by up to seven cycles
  task automatic set_ers(input logic v);
    @(posedge clk_sys);
    levelReq <= v;
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic quiet(input int n);
    int m;
    m = matchTotal;
    repeat (n) @(posedge clk_sys);
    check(8'(matchTotal - m), 8'h00);
  endtask

  task automatic wait_match(input int n);
    int k;
    k = 0;
    while (matchTotal == m0 && k < n) begin
      @(posedge clk_sys);
      k++;
    end
    check({7'h00, matchTotal != m0}, 8'h01);
    if (matchTotal == m0) wrap_up();
  endtask

  // Level left behind by the edge that starts each mode
  function automatic logic rise_lvl(input logic [4:0] m);
    return !(m[2:0] inside {3'h2, 3'h5, 3'h7});
  endfunction

  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int a = 4; a < 8; a++) wr(3'(a), 8'hA5);
    for (int a = 0; a < 8; a++) begin
      rd_reg(3'(a), rd);
      check(rd, (a == 1) ? PERIOD_RESET : 8'h00);
    end
    repeat (3) begin
      per = 8'($random(seed));
      wr(OFS_PERIOD, per);
      rd_reg(OFS_PERIOD, rd);
      check(rd, per);
    end
    per = 8'h03 + (8'($random(seed)) & 8'h07);
    wr(OFS_PERIOD, per);
    m0 = matchTotal;
    wr(OFS_CTRL, 8'h81);
    wait_match(300);
    m0 = matchTotal;
    p0 = pulseTotal;
    repeat (4 * (per + 1)) @(posedge clk_sys);
    check(8'(matchTotal - m0), 8'h04);
    check(8'(pulseTotal - p0), 8'h02);
    // Control write restarts the postscaler, so the next match gives no pulse
    wr(OFS_CTRL, 8'h81);
    m0 = matchTotal;
    p0 = pulseTotal;
    wait_match(60);
    check(8'(pulseTotal - p0), 8'h00);
    wr(OFS_CTRL, 8'h00);
    repeat (4) @(posedge clk_sys);
    quiet(30);
    for (int m = 1; m < 3; m++) begin
      set_ers(m == 2);
      wr(OFS_MODE, 8'(m));
      wr(OFS_CTRL, 8'h80);
      quiet(40);
      m0 = matchTotal;
      set_ers(m == 1);
      wait_match(60);
      wr(OFS_CTRL, 8'h00);
    end
    wr(OFS_PERIOD, 8'h28);
    for (int m = 3; m < 6; m++) begin
      wr(OFS_MODE, 8'(m));
      wr(OFS_CTRL, 8'h80);
      m0 = matchTotal;
      repeat (8) set_ers(!levelReq);
      check(8'(matchTotal - m0), 8'h00);
      wait_match(80);
      wr(OFS_CTRL, 8'h00);
    end
    wr(OFS_PERIOD, per);
    foreach (lvlModes[i]) begin
      md = lvlModes[i];
      set_ers(md[0]);
      wr(OFS_MODE, {3'h0, md});
      wr(OFS_CTRL, 8'h80);
      quiet(40);
      m0 = matchTotal;
      set_ers(!md[0]);
      wait_match(60);
      wr(OFS_CTRL, 8'h00);
    end
    m0 = matchTotal;
    wr(OFS_MODE, 8'h08);
    wr(OFS_CTRL, 8'h80);
    wait_match(60);
    foreach (edgeModes[i]) begin
      md = edgeModes[i];
      set_ers(!rise_lvl(md));
      wr(OFS_MODE, {3'h0, md});
      wr(OFS_CTRL, 8'h80);
      quiet(30);
      rd_reg(OFS_STATUS, rd);
      check(rd, {5'h00, !rise_lvl(md), 2'b10});
      m0 = matchTotal;
      set_ers(rise_lvl(md));
      wait_match(60);
      rd_reg(OFS_CTRL, rd);
      check({7'h00, rd[CTRL_ON_BIT]}, {7'h00, md[4]});
      wr(OFS_CTRL, 8'h00);
      wr(OFS_CTRL, 8'h80);
      quiet(30);
      wr(OFS_CTRL, 8'h00);
    end
    set_ers(1'b0);
    debugActive <= 1'b1;
    wr(OFS_MODE, 8'h09);
    wr(OFS_CTRL, 8'h80);
    set_ers(1'b1);
    quiet(30);
    wr(OFS_CTRL, 8'h00);
    wrap_up();
  end
endmodule
